//--- vcp_conv_model.sv
// Behavioural converter feeding the result FIFO of the port.
// Assumes the port's registered resultReady and converterReset on mclk.
`timescale 1ns/10ps
module vcp_conv_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Bench controls
	input wire logic run,
	input wire logic slow,
	// Port side
	input wire logic convReset,
	input wire logic resultReady,
	output logic resultValid,
	output logic [7:0] resultCode
);
	initial
	begin
		resultValid = 1'b0;
		resultCode = 8'h5a;
		forever
		begin
			@(posedge mclk);
			// Held off while the converter is in reset
			if (rstn && run && convReset === 1'b0 && resultReady === 1'b1)
			begin
				resultValid <= 1'b1;
				do @(posedge mclk); while (resultReady !== 1'b1);
				resultValid <= 1'b0;
				resultCode <= resultCode + 8'h01;
				if (slow)
					repeat (3) @(posedge mclk);
			end
		end
	end
endmodule // vcp_conv_model

//--- vcp_pkg.sv
// Shared constants for the vision chip command and readout port.
// Assumes one clock, mclk at 100 MHz, and active-low asynchronous reset.
package vcp_pkg;
	// Command word layout
	localparam int CMD_W = 12;
	localparam int HALF_W = 6;
	localparam int HALF_SEL_BIT = 7;
	localparam int DATA_W = 8;
	// Array size
	localparam int ARRAY_DIM = 256;
	localparam int PTR_W = 8;
	// Three-bit headers with nine-bit argument
	localparam logic [2:0] HDR_ROW_PTR = 3'h4;
	localparam logic [2:0] HDR_COL_PTR = 3'h5;
	localparam logic [2:0] HDR_HSW = 3'h6;
	localparam logic [2:0] HDR_VSW = 3'h7;
	// Six-bit headers with six-bit argument; locked bias header is four bits plus a two-bit index
	localparam logic [5:0] HDR_CTRL = 6'h01;
	localparam logic [5:0] HDR_CAP_LOAD = 6'h02;
	localparam logic [5:0] HDR_VAULT = 6'h03;
	localparam logic [5:0] HDR_ADC_OP = 6'h04;
	localparam logic [5:0] HDR_GAIN = 6'h05;
	localparam logic [5:0] HDR_OPEN_BIAS = 6'h0c;
	localparam logic [3:0] HDR_LOCKED_BIAS = 4'h2;
	// Control argument field positions
	localparam int CTRL_READ_STROBE = 0;
	localparam int CTRL_SUPPLY = 1;
	localparam int CTRL_GAIN_PATH = 2;
	localparam int CTRL_BYPASS_PATH = 3;
	localparam int CTRL_CAP_READ = 4;
	// Reset values, locked bias count and result FIFO depth
	localparam logic RST_SUPPLY_CTRL = 1'b1;
	localparam logic [5:0] RST_BIAS = 6'h20;
	localparam logic [5:0] RST_HALF = 6'h00;
	localparam int LOCKED_BIASES = 4;
	localparam int FIFO_DEPTH = 4;
	// Access tracking
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_WRITE = 2'b01,
		ACC_READ = 2'b10
	} vcp_acc_e;
endpackage

//--- vcp_port.sv
// Command assembly, decode and readout for the vision chip port, with result FIFO.
// Assumes host pins are synchronous to mclk; converter is an outside analog block.
//
// Summary of operation
// [RULE1] Commands are 12 bits: 3-bit header/9-bit arg or 6/6, header on top.
// [RULE2] Standard mode: command arrives as two six-bit writes on data lines.
// [RULE3] Upper half is held until the host writes a new upper half.
// [RULE4] Host may send only a lower half; the retained upper half completes it.
// [RULE5] Extended mode: whole command taken from twelve command lines at once.
// [RULE6] Pad drive and secondary analog route high when read and all selects high.
// [RULE7] Selected read drives the 8-bit converter result on the data lines.
// [RULE8] Converter runs from a command or directly from the direct strobe pin.
// [RULE9] Locked biases change only while the vault key is open.
// [RULE10] One row select per row, one column path per column.
// [RULE11] Row select i high only with row pointer i and read strobe high.
// [RULE12] Columns carry pixels only while switched supply control is 0.
// [RULE13] Gain path select routes columns through a four-setting amplifier.
// [RULE14] Bypass path select passes columns unchanged to the capacitor array.
// [RULE15] Load strobe captures amplifier outputs into the pointed capacitor row.
// [RULE16] Capacitor read strobe routes the row to the column select.
// [RULE17] Adjacent-capacitor switches, set by command, average blocks together.
// [RULE18] Reduced variant host drives only data lines 0 to 5 and 7, inbound.
// [RULE19] Direct strobe high resets converter, low lets conversion run; default 0.
// [RULE20] Write-not-read sets data line direction; floats toward read.
// [RULE21] Primary select active high; secondary selects active high.
// [RULE22] A command-load pulse marks each written command.
// [RULE23] Header decode picks one target; only that target updates.
// [RULE24] Read accesses change no control state.
`timescale 1ns/10ps

module vcp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_ff;
	logic [AW-1:0] rdPtr_ff;
	logic [AW:0] count_ff;
	logic push;
	logic pop;

	assign inReady = (count_ff != (AW+1)'(DEPTH));
	assign outValid = (count_ff != '0);
	assign outData = mem[rdPtr_ff];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge mclk)
	begin
		if (push)
		begin
			mem[wrPtr_ff] <= inData;
		end
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end
		else
		begin
			if (push)
			begin
				wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
			end
			if (pop)
			begin
				rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
			end
			if (push && !pop)
			begin
				count_ff <= count_ff + 1'b1;
			end
			else if (pop && !push)
			begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule // vcp_fifo

module vcp_port
	import vcp_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Host parallel port
	input wire logic [DATA_W-1:0] dataLinesIn,
	output logic [DATA_W-1:0] dataLinesOut,
	output logic dataLinesOe,
	input wire logic [CMD_W-1:0] commandLines,
	input wire logic extendedMode,
	input wire logic writeNotRead,
	input wire logic primarySelect,
	input wire logic [1:0] secondarySelects,
	// Pad controls
	output logic padDriveEnable,
	output logic secondaryAnalogRoute,
	output logic commandLoadPulse,
	// Converter
	input wire logic converterDirectStrobe,
	output logic converterReset,
	input wire logic resultValid,
	output logic resultReady,
	input wire logic [DATA_W-1:0] resultCode,
	// Focal plane and row amplifiers
	output logic [ARRAY_DIM-1:0] rowSelect,
	output logic columnsActive,
	output logic switchedSupplyCtrl,
	output logic gainPathSelect,
	output logic bypassPathSelect,
	output logic [1:0] gainSetting,
	// Capacitor array
	output logic [ARRAY_DIM-1:0] capLoadRow,
	output logic [ARRAY_DIM-1:0] capReadRow,
	output logic [ARRAY_DIM-1:0] columnPick,
	output logic [DATA_W-1:0] horizSwitches,
	output logic [DATA_W-1:0] vertSwitches,
	// Biases
	output logic vaultOpen,
	output logic [LOCKED_BIASES*HALF_W-1:0] lockedBias,
	output logic [HALF_W-1:0] openBias
);
	vcp_acc_e acc_ff;
	logic selected;
	logic wrStart;
	logic rdStart;
	logic [HALF_W-1:0] upperHalf_ff;
	logic cmdStb_ff;
	logic [CMD_W-1:0] cmdWord_ff;
	logic [2:0] hdr3;
	logic [5:0] hdr6;
	logic [8:0] arg9;
	logic [5:0] arg6;
	logic [PTR_W-1:0] rowPtr_ff;
	logic [PTR_W-1:0] colPtr_ff;
	logic readStrobe_ff;
	logic capRead_ff;
	logic capLoadStb_ff;
	logic adcCmdReset_ff;
	logic fifoValid;
	logic [DATA_W-1:0] fifoData;
	logic fifoInReady;

	// Access detection
	assign selected = primarySelect && (&secondarySelects); // see [RULE21]
	assign wrStart = selected && writeNotRead && (acc_ff == ACC_IDLE); // see [RULE20]
	assign rdStart = selected && !writeNotRead && (acc_ff == ACC_IDLE);

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			acc_ff <= ACC_IDLE;
		end
		else
		begin
			case (acc_ff)
				ACC_IDLE:
				begin
					if (wrStart)
					begin
						acc_ff <= ACC_WRITE;
					end
					else if (rdStart)
					begin
						acc_ff <= ACC_READ;
					end
				end
				ACC_WRITE, ACC_READ:
				begin
					if (!selected)
					begin
						acc_ff <= ACC_IDLE;
					end
				end
				default:
				begin
					acc_ff <= ACC_IDLE;
				end
			endcase
		end
	end

	// Command assembly
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			upperHalf_ff <= RST_HALF;
			cmdStb_ff <= 1'b0;
			cmdWord_ff <= '0;
		end
		else
		begin
			cmdStb_ff <= 1'b0;
			if (wrStart && extendedMode)
			begin
				cmdWord_ff <= commandLines; // see [RULE5]
				cmdStb_ff <= 1'b1;
			end
			else if (wrStart && dataLinesIn[HALF_SEL_BIT])
			begin
				upperHalf_ff <= dataLinesIn[HALF_W-1:0]; // see [RULE3]
			end
			else if (wrStart)
			begin
				cmdWord_ff <= {upperHalf_ff, dataLinesIn[HALF_W-1:0]}; // see [RULE2] [RULE4]
				cmdStb_ff <= 1'b1;
			end
		end
	end

	// Header and argument fields, header on top
	assign hdr3 = cmdWord_ff[CMD_W-1 -: 3]; // see [RULE1]
	assign hdr6 = cmdWord_ff[CMD_W-1 -: 6];
	assign arg9 = cmdWord_ff[8:0];
	assign arg6 = cmdWord_ff[5:0];

	// Load pulse follows each assembled command
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			commandLoadPulse <= 1'b0;
		end
		else
		begin
			commandLoadPulse <= cmdStb_ff; // see [RULE22]
		end
	end

	// Pointers and switch patterns
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rowPtr_ff <= '0;
			colPtr_ff <= '0;
			horizSwitches <= '0;
			vertSwitches <= '0;
		end
		else if (cmdStb_ff && hdr3[2])
		begin
			if (hdr3 == HDR_ROW_PTR) // see [RULE23]
			begin
				rowPtr_ff <= arg9[PTR_W-1:0];
			end
			else if (hdr3 == HDR_COL_PTR)
			begin
				colPtr_ff <= arg9[PTR_W-1:0];
			end
			else if (hdr3 == HDR_HSW)
			begin
				horizSwitches <= arg9[DATA_W-1:0]; // see [RULE17]
			end
			else
			begin
				vertSwitches <= arg9[DATA_W-1:0]; // see [RULE17]
			end
		end
	end

	// Path and strobe controls
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			readStrobe_ff <= 1'b0;
			switchedSupplyCtrl <= RST_SUPPLY_CTRL;
			gainPathSelect <= 1'b0;
			bypassPathSelect <= 1'b0;
			capRead_ff <= 1'b0;
			gainSetting <= 2'h0;
			capLoadStb_ff <= 1'b0;
			adcCmdReset_ff <= 1'b0;
		end
		else
		begin
			capLoadStb_ff <= cmdStb_ff && !hdr3[2] && (hdr6 == HDR_CAP_LOAD); // see [RULE15]
			if (cmdStb_ff && !hdr3[2] && (hdr6 == HDR_CTRL)) // see [RULE23]
			begin
				readStrobe_ff <= arg6[CTRL_READ_STROBE];
				switchedSupplyCtrl <= arg6[CTRL_SUPPLY];
				gainPathSelect <= arg6[CTRL_GAIN_PATH]; // see [RULE13]
				bypassPathSelect <= arg6[CTRL_BYPASS_PATH]; // see [RULE14]
				capRead_ff <= arg6[CTRL_CAP_READ];
			end
			if (cmdStb_ff && !hdr3[2] && (hdr6 == HDR_GAIN))
			begin
				gainSetting <= arg6[1:0]; // see [RULE13]
			end
			if (cmdStb_ff && !hdr3[2] && (hdr6 == HDR_ADC_OP))
			begin
				adcCmdReset_ff <= arg6[0]; // see [RULE8]
			end
		end
	end

	// Bias vault and bias values
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			vaultOpen <= 1'b0;
			lockedBias <= {LOCKED_BIASES{RST_BIAS}};
			openBias <= RST_BIAS;
		end
		else if (cmdStb_ff && !hdr3[2])
		begin
			if (hdr6 == HDR_VAULT)
			begin
				vaultOpen <= arg6[0];
			end
			else if (hdr6 == HDR_OPEN_BIAS)
			begin
				openBias <= arg6;
			end
			else if ((hdr6[5:2] == HDR_LOCKED_BIAS) && vaultOpen) // see [RULE9]
			begin
				lockedBias[hdr6[1:0]*HALF_W +: HALF_W] <= arg6;
			end
		end
	end

	// Per-row and per-column select lines
	genvar gi;
	generate
		for (gi = 0; gi < ARRAY_DIM; gi++)
		begin : g_lines
			always_ff @(posedge mclk or negedge rstn)
			begin
				if (!rstn)
				begin
					rowSelect[gi] <= 1'b0;
					capLoadRow[gi] <= 1'b0;
					capReadRow[gi] <= 1'b0;
					columnPick[gi] <= 1'b0;
				end
				else
				begin
					rowSelect[gi] <= readStrobe_ff && (rowPtr_ff == PTR_W'(gi)); // see [RULE10] [RULE11]
					capLoadRow[gi] <= capLoadStb_ff && (rowPtr_ff == PTR_W'(gi)); // see [RULE15]
					capReadRow[gi] <= capRead_ff && (rowPtr_ff == PTR_W'(gi)); // see [RULE16]
					columnPick[gi] <= capRead_ff && (colPtr_ff == PTR_W'(gi)); // see [RULE16]
				end
			end
		end
	endgenerate

	// Column lines live only with supply on and a row selected
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			columnsActive <= 1'b0;
		end
		else if (cmdStb_ff && !hdr3[2] && (hdr6 == HDR_CTRL))
		begin
			columnsActive <= arg6[CTRL_READ_STROBE] && !arg6[CTRL_SUPPLY]; // see [RULE12]
		end
	end

	// Converter reset from pin or command
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			converterReset <= 1'b0;
		end
		else
		begin
			converterReset <= converterDirectStrobe || adcCmdReset_ff; // see [RULE8] [RULE19]
		end
	end

	// Result buffer between converter and data lines
	vcp_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rstn(rstn),
		.inValid(resultValid),
		.inReady(fifoInReady),
		.inData(resultCode),
		.outValid(fifoValid),
		.outReady(rdStart),
		.outData(fifoData)
	);

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			resultReady <= 1'b0;
		end
		else
		begin
			resultReady <= fifoInReady && !resultValid;
		end
	end

	// Read side: pad drive and data lines
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			padDriveEnable <= 1'b0;
			secondaryAnalogRoute <= 1'b0;
			dataLinesOe <= 1'b0;
			dataLinesOut <= '0;
		end
		else
		begin
			padDriveEnable <= selected && !writeNotRead; // see [RULE6]
			secondaryAnalogRoute <= selected && !writeNotRead; // see [RULE6]
			dataLinesOe <= selected && !writeNotRead; // see [RULE7] [RULE20]
			if (rdStart && fifoValid)
			begin
				dataLinesOut <= fifoData; // see [RULE7] [RULE24]
			end
		end
	end
endmodule // vcp_port

//--- vcp_port_assertions.sv
// Port checker for the vision chip command and readout port.
// Assumes binding to vcp_port, one clock mclk, reset rstn.
`timescale 1ns/10ps
module vcp_port_assertions
	import vcp_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Host port
	input wire logic writeNotRead,
	input wire logic primarySelect,
	input wire logic [1:0] secondarySelects,
	input wire logic dataLinesOe,
	input wire logic padDriveEnable,
	input wire logic secondaryAnalogRoute,
	input wire logic commandLoadPulse,
	// Converter
	input wire logic converterDirectStrobe,
	input wire logic converterReset,
	// Array
	input wire logic [ARRAY_DIM-1:0] rowSelect,
	input wire logic [ARRAY_DIM-1:0] capLoadRow,
	input wire logic [ARRAY_DIM-1:0] capReadRow,
	input wire logic [ARRAY_DIM-1:0] columnPick,
	input wire logic columnsActive,
	input wire logic switchedSupplyCtrl,
	input wire logic [1:0] gainSetting,
	// Biases
	input wire logic vaultOpen,
	input wire logic [LOCKED_BIASES*HALF_W-1:0] lockedBias
);
	logic rdSel;
	assign rdSel = primarySelect & (&secondarySelects) & !writeNotRead;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	a_pad_drive: assert property (padDriveEnable == $past(rdSel))
		else $error("pad drive mismatch");
	a_analog_route: assert property (secondaryAnalogRoute == padDriveEnable)
		else $error("analog route mismatch");
	a_oe_follow: assert property (dataLinesOe == padDriveEnable)
		else $error("data drive mismatch");
	a_row_onehot: assert property ($onehot0(rowSelect))
		else $error("row select not one-hot");
	a_supply_on: assert property (columnsActive |-> !switchedSupplyCtrl)
		else $error("columns active with supply off");
	a_col_pair: assert property ((capReadRow != '0) == (columnPick != '0))
		else $error("column pick without read row");
	a_cap_load: assert property ((capLoadRow != '0) |->
		($past(commandLoadPulse) && $onehot(capLoadRow)) ##1 (capLoadRow == '0))
		else $error("capacitor load pulse bad");
	a_load_pulse: assert property (commandLoadPulse |=> !commandLoadPulse)
		else $error("load pulse too long");
	a_ctrl_quiet: assert property ($changed(gainSetting) |-> commandLoadPulse)
		else $error("gain changed without command");
	a_vault_lock: assert property ($changed(lockedBias) |-> $past(vaultOpen))
		else $error("locked bias changed while closed");
	a_conv_reset: assert property ($past(converterDirectStrobe) |-> converterReset)
		else $error("converter reset missing");
	c_load: cover property (commandLoadPulse);
	c_read: cover property (dataLinesOe);
	c_bias: cover property ($changed(lockedBias));
	c_conv: cover property (converterReset);
endmodule // vcp_port_assertions

//--- vcp_port_test.sv
// Self-checking bench for vcp_port with converter model and checker.
// Assumes vcp_pkg, vcp_fifo, vcp_port, vcp_conv_model compiled first.
`timescale 1ns/10ps
module vcp_port_test
	import vcp_pkg::*;
;
	typedef struct {logic [3:0] k; logic [255:0] v;} vcp_exp_s;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] dataLinesIn = 8'h00;
	logic [11:0] commandLines = 12'h000;
	logic extendedMode = 1'b0, writeNotRead = 1'b0, primarySelect = 1'b0;
	logic [1:0] secondarySelects = 2'h3;
	logic converterDirectStrobe = 1'b0, run = 1'b0, slow = 1'b0;
	logic [7:0] dataLinesOut, resultCode;
	logic dataLinesOe, padDriveEnable, secondaryAnalogRoute, commandLoadPulse;
	logic converterReset, resultValid, resultReady, columnsActive, switchedSupplyCtrl;
	logic gainPathSelect, bypassPathSelect, vaultOpen;
	logic [1:0] gainSetting;
	logic [255:0] rowSelect, capLoadRow, capReadRow, columnPick;
	logic [7:0] horizSwitches, vertSwitches;
	logic [23:0] lockedBias;
	logic [5:0] openBias;
	logic [31:0] seed = 32'h32164154;
	vcp_exp_s qc[$], qr[$], ec, er;
	int n_errors = 0, cmp_count = 0;
	vcp_port vcp_port_inst (.mclk, .rstn, .dataLinesIn, .dataLinesOut, .dataLinesOe,
		.commandLines, .extendedMode, .writeNotRead, .primarySelect, .secondarySelects,
		.padDriveEnable, .secondaryAnalogRoute, .commandLoadPulse, .converterDirectStrobe,
		.converterReset, .resultValid, .resultReady, .resultCode, .rowSelect, .columnsActive,
		.switchedSupplyCtrl, .gainPathSelect, .bypassPathSelect, .gainSetting, .capLoadRow,
		.capReadRow, .columnPick, .horizSwitches, .vertSwitches, .vaultOpen, .lockedBias,
		.openBias);
	vcp_conv_model vcp_conv_model_inst (.mclk, .rstn, .run, .slow, .convReset(converterReset),
		.resultReady, .resultValid, .resultCode);
	initial
	begin
		forever #5 mclk = ~mclk;
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [255:0] obs(input logic [3:0] k);
		case (k)
			0: obs = dataLinesOut;
			1: obs = gainSetting;
			2: obs = horizSwitches;
			3: obs = vertSwitches;
			4: obs = lockedBias;
			5: obs = openBias;
			6: obs = rowSelect;
			7: obs = capLoadRow;
			8: obs = columnPick;
			9: obs = {columnsActive, switchedSupplyCtrl, gainPathSelect, bypassPathSelect};
			11: obs = converterReset;
			default: obs = vaultOpen;
		endcase
	endfunction
	task chk(input logic [255:0] got, input logic [255:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task end_of_test();
		$display("Counts: %0d mismatches, %0d compares", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] d);
		@(negedge mclk);
		dataLinesIn = d;
		writeNotRead = 1'b1;
		primarySelect = 1'b1;
		@(negedge mclk);
		primarySelect = 1'b0;
		dataLinesIn = ~d;
	endtask
	task cmd(input logic [11:0] c, input int m, input logic [3:0] k, input logic [255:0] v);
		qc.push_back('{k, v});
		if (m == 2)
		begin
			extendedMode = 1'b1;
			commandLines = c;
			wr(8'h00);
			commandLines = ~c;
		end
		else
		begin
			if (m == 1)
				wr({2'b10, c[11:6]});
			wr({2'b00, c[5:0]});
		end
		for (int i = 0; i < 20 && qc.size() != 0; i++) @(negedge mclk);
		extendedMode = 1'b0;
		if (qc.size() != 0)
			chk(qc.size(), 0);
	endtask
	task rd(input logic [7:0] e, input bit push);
		if (push)
			qr.push_back('{0, e});
		@(negedge mclk);
		writeNotRead = 1'b0;
		primarySelect = 1'b1;
		repeat (2) @(negedge mclk);
		primarySelect = 1'b0;
	endtask
	always @(negedge mclk)
		if (commandLoadPulse === 1'b1)
		begin
			@(negedge mclk);
			if (qc.size() != 0)
				ec = qc.pop_front();
			else
				ec = '{4'hf, 256'h2};
			chk(obs(ec.k), ec.v);
		end
	always @(posedge dataLinesOe)
	begin
		@(negedge mclk);
		if (qr.size() != 0)
			er = qr.pop_front();
		else
			er = '{4'h0, ~dataLinesOut};
		chk(dataLinesOut, er.v);
		chk({padDriveEnable, secondaryAnalogRoute}, 2'b11);
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		end_of_test();
	end
	initial
	begin
		logic [31:0] r;
		logic [7:0] p, q;
		repeat (16) @(negedge mclk);
		rstn = 1'b1;
		chk(switchedSupplyCtrl, RST_SUPPLY_CTRL);
		chk(lockedBias, {4{RST_BIAS}});
		chk(openBias, RST_BIAS);
		$display("Test reset values done");
		r = rnd();
		cmd({HDR_GAIN, 4'h0, r[1:0]}, 1, 1, r[1:0]);
		cmd({HDR_GAIN, 4'h0, r[3:2]}, 0, 1, r[3:2]);
		cmd({HDR_HSW, 1'b0, r[15:8]}, 1, 2, r[15:8]);
		cmd({HDR_VSW, 1'b0, r[23:16]}, 1, 3, r[23:16]);
		cmd({HDR_OPEN_BIAS, r[29:24]}, 1, 5, r[29:24]);
		$display("Test command targets done");
		cmd({HDR_LOCKED_BIAS, 2'h1, r[5:0] | 6'h01}, 1, 4, {4{RST_BIAS}});
		cmd({HDR_VAULT, 6'h01}, 1, 10, 1);
		cmd({HDR_LOCKED_BIAS, 2'h1, r[5:0] | 6'h01}, 1, 4,
			{RST_BIAS, RST_BIAS, r[5:0] | 6'h01, RST_BIAS});
		cmd({HDR_VAULT, 6'h00}, 1, 10, 0);
		$display("Test vault done");
		r = rnd();
		p = r[7:0];
		q = r[15:8];
		cmd({HDR_ROW_PTR, 1'b0, p}, 1, 6, 0);
		cmd({HDR_CTRL, 6'h19}, 1, 6, 256'h1 << p);
		cmd({HDR_CAP_LOAD, 6'h00}, 1, 7, 256'h1 << p);
		cmd({HDR_COL_PTR, 1'b0, q}, 2, 8, 256'h1 << q);
		chk(capReadRow, 256'h1 << p);
		cmd({HDR_CTRL, 6'h05}, 1, 9, 4'ha);
		cmd({HDR_CTRL, 6'h02}, 0, 9, 4'h4);
		cmd({HDR_ADC_OP, 6'h01}, 1, 11, 1);
		cmd({HDR_ADC_OP, 6'h00}, 0, 11, 0);
		$display("Test array path done");
		run = 1'b1;
		repeat (30) @(negedge mclk);
		run = 1'b0;
		for (int i = 0; i < 4; i++) rd(8'h5a + i[7:0], 1);
		rd(8'h5d, 1);
		secondarySelects = 2'h1;
		rd(8'h00, 0);
		chk({dataLinesOe, padDriveEnable, secondaryAnalogRoute}, 3'h0);
		secondarySelects = 2'h3;
		converterDirectStrobe = 1'b1;
		repeat (2) @(negedge mclk);
		chk(converterReset, 1'b1);
		run = 1'b1;
		slow = 1'b1;
		repeat (20) @(negedge mclk);
		rd(8'h5d, 1);
		converterDirectStrobe = 1'b0;
		repeat (2) @(negedge mclk);
		chk(converterReset, 1'b0);
		repeat (40) @(negedge mclk);
		run = 1'b0;
		for (int i = 0; i < 4; i++) rd(8'h5e + i[7:0], 1);
		repeat (4) @(negedge mclk);
		chk(qr.size(), 0);
		$display("Test readout done");
		end_of_test();
	end
endmodule // vcp_port_test
bind vcp_port vcp_port_assertions vcp_port_assertions_inst (.mclk, .rstn, .writeNotRead,
	.primarySelect, .secondarySelects, .dataLinesOe, .padDriveEnable, .secondaryAnalogRoute,
	.commandLoadPulse, .converterDirectStrobe, .converterReset, .rowSelect, .capLoadRow,
	.capReadRow, .columnPick, .columnsActive, .switchedSupplyCtrl, .gainSetting, .vaultOpen,
	.lockedBias);
